/* File: shared/ssbs_pkg.sv */
package ssbs_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS  = 10;
   localparam int INDEX_UNIT_US  = 100;
   localparam int TENTH_CYCLES   = (INDEX_UNIT_US * 1000) / CLK_PERIOD_NS;
   localparam int TENTHS_PER_MS  = 10;

   // register byte offsets
   localparam logic [7:0] REG_STOP_MODE   = 8'h00;
   localparam logic [7:0] REG_DECEL_TORQ  = 8'h04;
   localparam logic [7:0] REG_DECEL_TIME  = 8'h08;
   localparam logic [7:0] REG_REL_DELAY   = 8'h0c;
   localparam logic [7:0] REG_STAT_DELAY  = 8'h10;
   localparam logic [7:0] REG_SPEED_THR   = 8'h14;
   localparam logic [7:0] REG_ROT_WAIT    = 8'h18;
   localparam logic [7:0] REG_IDX_WIDTH   = 8'h1c;
   localparam logic [7:0] REG_CONTROL     = 8'h20;
   localparam logic [7:0] REG_STATUS      = 8'h24;

   // field positions
   localparam int BASE_MODE_LSB   = 0;
   localparam int FORCED_MODE_LSB = 4;
   localparam int CTL_ENABLE_BIT  = 0;
   localparam int CTL_FORCE_BIT   = 1;
   localparam int ST_BRAKE_BIT    = 4;
   localparam int ST_POWER_BIT    = 5;
   localparam int ST_ACCEPT_BIT   = 6;
   localparam int ST_DB_BIT       = 7;
   localparam int ST_DECEL_BIT    = 8;

   // setting limits
   localparam logic [15:0] MAX_DECEL_TORQ = 16'h015e;
   localparam logic [15:0] MAX_DECEL_TIME = 16'hea60;
   localparam logic [15:0] MAX_DELAY_500  = 16'h01f4;
   localparam logic [15:0] MAX_SPEED_THR  = 16'h1770;
   localparam logic [15:0] MAX_ROT_WAIT   = 16'h03e8;
   localparam logic [15:0] MAX_IDX_WIDTH  = 16'h03e8;
   localparam logic [1:0]  MAX_MODE       = 2'h2;

   // values after reset, and the index width used for a zero setting
   localparam logic [9:0]  IDX_DEFAULT_WIDTH = 10'h001;
   localparam logic [1:0]  RST_MODE          = 2'h0;
   localparam logic [15:0] RST_SETTING       = 16'h0000;

   typedef enum logic [2:0] {
      SSBS_OFF,
      SSBS_RELEASE,
      SSBS_RUN,
      SSBS_DECEL,
      SSBS_HOLD_STATIC,
      SSBS_HOLD_ROT
   } ssbs_state_t;

   typedef struct packed {
      ssbs_state_t state;
      logic [15:0] msCount;
      logic [9:0]  idxCount;
      logic        idxOut;
      logic [1:0]  baseMode;
      logic [1:0]  forcedMode;
      logic [8:0]  decelTorque;
      logic [15:0] decelTime;
      logic [8:0]  releaseDelay;
      logic [8:0]  staticDelay;
      logic [12:0] speedThr;
      logic [9:0]  rotWait;
      logic [9:0]  idxWidth;
      logic        enableCmd;
      logic        forceCmd;
      logic [31:0] rdata;
   } ssbs_core_t;

   typedef struct packed {
      logic [16:0] cycles;
      logic [3:0]  tenths;
      logic        tickTenth;
      logic        tickMs;
   } ssbs_tick_t;
endpackage

/* File: shared/ssbs_tick_if.sv */
interface ssbs_tick_if;
   logic tickTenth;
   logic tickMs;
   modport src (output tickTenth, output tickMs);
   modport dst (input tickTenth, input tickMs);
endinterface

/* File: rtl/ssbs_tick_gen.sv */
module ssbs_tick_gen #(
   parameter int TENTH_MS_CYCLES = ssbs_pkg::TENTH_CYCLES
) (
   input  wire logic   sys_clk,
   input  wire logic   rst,
   input  wire logic   ce,
   ssbs_tick_if.src    tick
);
   import ssbs_pkg::*;

   localparam logic [16:0] LAST_CYCLE = 17'(TENTH_MS_CYCLES - 1);
   localparam logic [3:0]  LAST_TENTH = 4'(TENTHS_PER_MS - 1);

   ssbs_tick_t r_reg;
   ssbs_tick_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tickTenth = 1'b0;
      r_next.tickMs = 1'b0;
      if (r_reg.cycles == LAST_CYCLE) begin
         r_next.cycles = '0;
         r_next.tickTenth = 1'b1;
         if (r_reg.tenths == LAST_TENTH) begin
            r_next.tenths = '0;
            r_next.tickMs = 1'b1; // see RL12
         end else begin
            r_next.tenths = r_reg.tenths + 4'h1;
         end
      end else begin
         r_next.cycles = r_reg.cycles + 17'h00001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_reg <= '0;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   // ticks are one-cycle pulses, masked so a frozen block never sees one twice
   assign tick.tickTenth = r_reg.tickTenth & ce;
   assign tick.tickMs = r_reg.tickMs & ce;
endmodule

/* File: rtl/ssbs_sequencer.sv */
// Behaviour
// RL1: forced stop uses base mode, torque decel or timed decel, then base mode
// RL2: hold decel-stop torque 0..350 percent, used for torque-based stops
// RL3: hold decel-stop time 0..60000 ms, used for time-based stops
// RL4: after brake release wait 0..500 ms before accepting motion commands
// RL5: after enable ignore position commands until static brake delay elapses
// RL6: stationary disable engages brake, keeps power for static delay, then off
// RL7: rotating disable asserts brake once speed drops below threshold 0..6000 rpm
// RL8: rotating disable asserts brake anyway when max wait 0..1000 ms expires
// RL9: index width setting 0..1000 in 0.1 ms; zero gives default width
// RL10: nonzero index width makes each index pulse last that many 0.1 ms
// RL11: base stop mode: 0 brake and hold, 1 brake then release, 2 coast
// RL12: all ms delays counted on common 1 ms tick, restarted per event
module ssbs_sequencer #(
   parameter int TENTH_MS_CYCLES = ssbs_pkg::TENTH_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [12:0] motorSpeed,
   input  wire logic        posCmdValid,
   output logic             posCmdAccept,
   input  wire logic        indexEvent,
   output logic             indexPulse,
   output logic             holdBrake,
   output logic             motorPower,
   output logic             dynamicBrake,
   output logic             decelTorqueMode,
   output logic      [8:0]  decelTorqueLimit,
   output logic             decelTimeMode,
   output logic      [15:0] decelTimeMs
);
   import ssbs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [15:0] clampSetting(input logic [31:0] v,
                                                input logic [15:0] lim);
      logic [15:0] res;
      res = (v > {16'h0000, lim}) ? lim : v[15:0];
      return res;
   endfunction

   function automatic logic expired(input logic [15:0] cnt,
                                    input logic [15:0] lim);
      logic res;
      res = (cnt >= lim);
      return res;
   endfunction

   function automatic ssbs_core_t goTo(input ssbs_core_t c,
                                       input ssbs_state_t s);
      ssbs_core_t res;
      res = c;
      res.state = s;
      res.msCount = '0;
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // time base

   ssbs_tick_if tick ();

   ssbs_tick_gen #(
      .TENTH_MS_CYCLES (TENTH_MS_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .tick    (tick)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state

   ssbs_core_t r_reg;
   ssbs_core_t r_next;

   logic        apbWrite;
   logic        apbSetup;
   logic        mapped;
   logic        stationary;
   logic        belowThr;
   logic [15:0] acceptDelay;
   logic [31:0] statusWord;
   logic [9:0]  idxTarget;

   assign apbWrite = psel & penable & pwrite;
   assign apbSetup = psel & ~penable;
   assign stationary = (motorSpeed == 13'h0000);
   assign belowThr = (motorSpeed < r_reg.speedThr); // see RL7
   // commands wait for both delays, the brake release and enable start together
   assign acceptDelay = (r_reg.releaseDelay > r_reg.staticDelay) ? {7'h00, r_reg.releaseDelay}
                                                                 : {7'h00, r_reg.staticDelay};
   assign idxTarget = (r_reg.idxWidth == 10'h000) ? IDX_DEFAULT_WIDTH : r_reg.idxWidth; // see RL9

   always_comb begin
      mapped = 1'b1;
      case (paddr)
         REG_STOP_MODE, REG_DECEL_TORQ, REG_DECEL_TIME, REG_REL_DELAY, REG_STAT_DELAY,
         REG_SPEED_THR, REG_ROT_WAIT, REG_IDX_WIDTH, REG_CONTROL, REG_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      statusWord = '0;
      statusWord[2:0] = r_reg.state;
      statusWord[ST_BRAKE_BIT] = holdBrake;
      statusWord[ST_POWER_BIT] = motorPower;
      statusWord[ST_ACCEPT_BIT] = (r_reg.state == SSBS_RUN);
      statusWord[ST_DB_BIT] = dynamicBrake;
      statusWord[ST_DECEL_BIT] = (r_reg.state == SSBS_DECEL);
   end

   always_comb begin
      r_next = r_reg;

      // register writes, settings clamped to their legal ranges
      if (apbWrite) begin
         case (paddr)
            REG_STOP_MODE: begin
               r_next.baseMode = (pwdata[BASE_MODE_LSB+:2] > MAX_MODE) ? MAX_MODE
                                                                        : pwdata[BASE_MODE_LSB+:2];
               r_next.forcedMode = (pwdata[FORCED_MODE_LSB+:2] > MAX_MODE) ? MAX_MODE
                                                                            : pwdata[FORCED_MODE_LSB+:2];
            end
            REG_DECEL_TORQ: r_next.decelTorque = 9'(clampSetting(pwdata, MAX_DECEL_TORQ)); // see RL2
            REG_DECEL_TIME: r_next.decelTime = clampSetting(pwdata, MAX_DECEL_TIME); // see RL3
            REG_REL_DELAY: r_next.releaseDelay = 9'(clampSetting(pwdata, MAX_DELAY_500)); // see RL4
            REG_STAT_DELAY: r_next.staticDelay = 9'(clampSetting(pwdata, MAX_DELAY_500)); // see RL5
            REG_SPEED_THR: r_next.speedThr = 13'(clampSetting(pwdata, MAX_SPEED_THR)); // see RL7
            REG_ROT_WAIT: r_next.rotWait = 10'(clampSetting(pwdata, MAX_ROT_WAIT)); // see RL8
            REG_IDX_WIDTH: r_next.idxWidth = 10'(clampSetting(pwdata, MAX_IDX_WIDTH)); // see RL9
            REG_CONTROL: begin
               r_next.enableCmd = pwdata[CTL_ENABLE_BIT];
               r_next.forceCmd = pwdata[CTL_FORCE_BIT];
            end
            default: r_next.enableCmd = r_reg.enableCmd;
         endcase
      end

      // read data captured in the setup cycle so the access phase needs no wait
      if (apbSetup) begin
         case (paddr)
            REG_STOP_MODE: r_next.rdata = {26'h0, r_reg.forcedMode, 2'h0, r_reg.baseMode};
            REG_DECEL_TORQ: r_next.rdata = {23'h0, r_reg.decelTorque};
            REG_DECEL_TIME: r_next.rdata = {16'h0, r_reg.decelTime};
            REG_REL_DELAY: r_next.rdata = {23'h0, r_reg.releaseDelay};
            REG_STAT_DELAY: r_next.rdata = {23'h0, r_reg.staticDelay};
            REG_SPEED_THR: r_next.rdata = {19'h0, r_reg.speedThr};
            REG_ROT_WAIT: r_next.rdata = {22'h0, r_reg.rotWait};
            REG_IDX_WIDTH: r_next.rdata = {22'h0, r_reg.idxWidth};
            REG_CONTROL: r_next.rdata = {30'h0, r_reg.forceCmd, r_reg.enableCmd};
            REG_STATUS: r_next.rdata = statusWord;
            default: r_next.rdata = '0;
         endcase
      end

      // ms counter saturates so long waits never wrap into a false expiry
      if (tick.tickMs && (r_reg.msCount != 16'hffff)) begin
         r_next.msCount = r_reg.msCount + 16'h0001; // see RL12
      end

      case (r_reg.state)
         SSBS_OFF: begin
            if (r_reg.enableCmd && !r_reg.forceCmd) begin
               r_next = goTo(r_next, SSBS_RELEASE); // see RL12
            end
         end
         SSBS_RELEASE: begin
            if (r_reg.forceCmd || !r_reg.enableCmd) begin
               r_next = goTo(r_next, stationary ? SSBS_HOLD_STATIC : SSBS_HOLD_ROT);
            end else if (expired(r_reg.msCount, acceptDelay)) begin
               r_next = goTo(r_next, SSBS_RUN); // see RL4 // see RL5
            end
         end
         SSBS_RUN: begin
            if (r_reg.forceCmd) begin
               case (r_reg.forcedMode)
                  2'h1, 2'h2: r_next = goTo(r_next, SSBS_DECEL); // see RL1
                  default: r_next = goTo(r_next, stationary ? SSBS_HOLD_STATIC : SSBS_HOLD_ROT); // see RL1
               endcase
            end else if (!r_reg.enableCmd) begin
               r_next = goTo(r_next, stationary ? SSBS_HOLD_STATIC : SSBS_HOLD_ROT);
            end
         end
         SSBS_DECEL: begin
            // once stopped the base stop mode takes over through the off path
            if (stationary) begin
               r_next = goTo(r_next, SSBS_HOLD_STATIC); // see RL1
            end
         end
         SSBS_HOLD_STATIC: begin
            if (expired(r_reg.msCount, {7'h00, r_reg.staticDelay})) begin
               r_next = goTo(r_next, SSBS_OFF); // see RL6
            end
         end
         SSBS_HOLD_ROT: begin
            if (belowThr) begin
               r_next = goTo(r_next, SSBS_OFF); // see RL7
            end else if (expired(r_reg.msCount, {6'h00, r_reg.rotWait})) begin
               r_next = goTo(r_next, SSBS_OFF); // see RL8
            end
         end
         default: r_next = goTo(r_next, SSBS_OFF);
      endcase

      // index pulse, a new event restarts the width count
      if (indexEvent) begin
         r_next.idxOut = 1'b1;
         r_next.idxCount = '0;
      end else if (r_reg.idxOut && tick.tickTenth) begin
         if ((r_reg.idxCount + 10'h001) >= idxTarget) begin
            r_next.idxOut = 1'b0; // see RL10
            r_next.idxCount = '0;
         end else begin
            r_next.idxCount = r_reg.idxCount + 10'h001; // see RL10
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.state <= SSBS_OFF;
         r_reg.baseMode <= RST_MODE;
         r_reg.forcedMode <= RST_MODE;
         r_reg.decelTorque <= 9'(RST_SETTING);
         r_reg.decelTime <= RST_SETTING;
      end else if (ce) begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, decoded from registered state and live inputs, pslverr from the bus alone

   assign prdata = r_reg.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   assign posCmdAccept = posCmdValid & (r_reg.state == SSBS_RUN); // see RL5
   assign indexPulse = r_reg.idxOut;

   // brake engaged everywhere except while releasing, running, decelerating or still spinning down
   assign holdBrake = (r_reg.state == SSBS_OFF) || (r_reg.state == SSBS_HOLD_STATIC); // see RL6
   // power stays on through the static hold, the stationary brake needs time to bite
   assign motorPower = (r_reg.state == SSBS_RELEASE) || (r_reg.state == SSBS_RUN) ||
                       (r_reg.state == SSBS_DECEL) || (r_reg.state == SSBS_HOLD_STATIC); // see RL6

   always_comb begin
      dynamicBrake = 1'b0;
      if ((r_reg.state == SSBS_OFF) || (r_reg.state == SSBS_HOLD_ROT)) begin
         case (r_reg.baseMode)
            2'h0: dynamicBrake = 1'b1; // see RL11
            2'h1: dynamicBrake = ~stationary; // see RL11
            default: dynamicBrake = 1'b0; // see RL11
         endcase
      end
   end

   assign decelTorqueMode = (r_reg.state == SSBS_DECEL) && (r_reg.forcedMode == 2'h1); // see RL2
   assign decelTimeMode = (r_reg.state == SSBS_DECEL) && (r_reg.forcedMode == 2'h2); // see RL3
   assign decelTorqueLimit = r_reg.decelTorque;
   assign decelTimeMs = r_reg.decelTime;
endmodule

/* File: bench/ssbs_sva.sv */
module ssbs_sva #(
   parameter int TENTH_MS_CYCLES = ssbs_pkg::TENTH_CYCLES
) (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic [12:0] motorSpeed,
   input wire logic        posCmdValid,
   input wire logic        posCmdAccept,
   input wire logic        indexEvent,
   input wire logic        indexPulse,
   input wire logic        holdBrake,
   input wire logic        motorPower,
   input wire logic        dynamicBrake,
   input wire logic        decelTorqueMode,
   input wire logic [8:0]  decelTorqueLimit,
   input wire logic        decelTimeMode,
   input wire logic [15:0] decelTimeMs
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] rotCnt;
   logic [31:0] idxCnt;
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   // counters instead of long repetitions, which would not unroll
   always_ff @(posedge sys_clk) begin
      if (rst || motorPower || holdBrake)
         rotCnt <= 32'h0;
      else if (ce)
         rotCnt <= rotCnt + 32'h1;
      if (rst || indexEvent || !indexPulse)
         idxCnt <= 32'h0;
      else if (ce)
         idxCnt <= idxCnt + 32'h1;
   end
   ////////////////////////////////////////////////////////////
   accept_gate_a: assert property (posCmdAccept |-> posCmdValid && motorPower && !holdBrake)
      else $error("position command taken outside run");
   release_wait_a: assert property ($rose(motorPower) |-> !holdBrake && !posCmdAccept)
      else $error("command taken at brake release");
   static_order_a: assert property ($fell(motorPower) && $past(motorSpeed) == 13'h0 |-> $past(holdBrake))
      else $error("power removed before brake engaged");
   decel_power_a: assert property (decelTorqueMode || decelTimeMode |-> motorPower && !holdBrake && !dynamicBrake)
      else $error("decel without drive");
   db_release_a: assert property (motorPower |-> !dynamicBrake)
      else $error("dynamic brake while powered");
   torque_range_a: assert property (decelTorqueLimit <= 9'h15e)
      else $error("decel torque above range");
   time_range_a: assert property (decelTimeMs <= 16'hea60)
      else $error("decel time above range");
   index_start_a: assert property (indexEvent && ce |=> indexPulse)
      else $error("index pulse missing");
   index_width_a: assert property (idxCnt <= 1000 * TENTH_MS_CYCLES + 2)
      else $error("index pulse too long");
   rot_wait_a: assert property (rotCnt <= 10010 * TENTH_MS_CYCLES + 2)
      else $error("rotating brake wait overrun");
endmodule

bind ssbs_sequencer ssbs_sva #(.TENTH_MS_CYCLES(TENTH_MS_CYCLES)) ssbs_sva_i (.sys_clk, .rst, .ce, .motorSpeed,
   .posCmdValid, .posCmdAccept, .indexEvent, .indexPulse, .holdBrake, .motorPower, .dynamicBrake,
   .decelTorqueMode, .decelTorqueLimit, .decelTimeMode, .decelTimeMs);

/* File: bench/ssbs_plant.sv */
module ssbs_plant (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        motorPower,
   input  wire logic        holdBrake,
   input  wire logic        decelMode,
   input  wire logic [12:0] targetSpeed,
   output logic      [12:0] motorSpeed,
   output logic             indexEvent
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] turnCnt;
   // driven shaft jumps to target; otherwise it slows 100 rpm a cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         motorSpeed <= 13'h0;
         turnCnt    <= 14'h0;
      end else begin
         turnCnt <= turnCnt + 14'h1;
         if (motorPower && !holdBrake && !decelMode)
            motorSpeed <= targetSpeed;
         else if (motorSpeed > 13'h64)
            motorSpeed <= motorSpeed - 13'h64;
         else
            motorSpeed <= 13'h0;
      end
   end
   // one mark a turn, long period so the widest pulse is not restarted
   assign indexEvent = motorSpeed != 13'h0 && turnCnt == 14'h3fff;
endmodule

/* File: bench/tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssbs_pkg::*;
   localparam int TMS = 10;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        posCmdValid = 1'b0;
   logic [7:0]  paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [12:0] targetSpeed = 13'h0;
   logic [31:0] prdata, rd;
   logic [12:0] motorSpeed;
   logic [8:0]  decelTorqueLimit;
   logic [15:0] decelTimeMs;
   logic        pready, pslverr, err, posCmdAccept, indexEvent, indexPulse, holdBrake;
   logic        motorPower, dynamicBrake, decelTorqueMode, decelTimeMode;
   int          n_fail = 0;
   int          comparisons = 0;
   int          n;

   ssbs_sequencer #(.TENTH_MS_CYCLES(TMS)) ssbs_sequencer_i (.sys_clk, .rst, .ce, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata, .pready, .pslverr, .motorSpeed, .posCmdValid, .posCmdAccept, .indexEvent,
      .indexPulse, .holdBrake, .motorPower, .dynamicBrake, .decelTorqueMode, .decelTorqueLimit,
      .decelTimeMode, .decelTimeMs);
   ssbs_plant ssbs_plant_i (.sys_clk, .rst, .motorPower, .holdBrake, .decelMode(decelTorqueMode | decelTimeMode),
      .targetSpeed, .motorSpeed, .indexEvent);
   ////////////////////////////////////////////////////////////
   task automatic wrap_up();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask

   // the extra edge at the end keeps psel from being assigned twice in one step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd  = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         $display("[FAIL] pready expected 1 seen %b", pready);
         n_fail++;
         wrap_up();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic waitFor(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      if (s !== v) begin
         n_fail++;
         $display("[FAIL] wait expected %h seen %h", v, s);
         wrap_up();
      end
   endtask
   ////////////////////////////////////////////////////////////
   task automatic s_reset();
      chk("brake", holdBrake, 32'h1);
      apb(1'b0, REG_STATUS, 32'h0);
      chk("status", rd, 32'h90);
   endtask

   task automatic s_regs();
      logic [7:0]  ad[8] = '{REG_STOP_MODE, REG_DECEL_TORQ, REG_DECEL_TIME, REG_REL_DELAY, REG_STAT_DELAY,
                             REG_SPEED_THR, REG_ROT_WAIT, REG_IDX_WIDTH};
      logic [31:0] wv[8] = '{32'h33, 32'h15f, 32'hea61, 32'h1f5, 32'h1f5, 32'h1771, 32'h3e9, 32'h3e9};
      logic [31:0] ev[8] = '{32'h22, 32'h15e, 32'hea60, 32'h1f4, 32'h1f4, 32'h1770, 32'h3e8, 32'h3e8};
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, ad[i], wv[i]);
         apb(1'b0, ad[i], 32'h0);
         chk("setting", rd, ev[i]);
      end
      chk("torque", decelTorqueLimit, 32'h15e);
      chk("time", decelTimeMs, 32'hea60);
      apb(1'b1, 8'h40, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {rd[30:0], err}, 32'h1);
   endtask

   // a write issued while the block is frozen must not land
   task automatic s_freeze();
      ce <= 1'b0;
      apb(1'b1, REG_DECEL_TORQ, 32'h10);
      ce <= 1'b1;
      apb(1'b0, REG_DECEL_TORQ, 32'h0);
      chk("frozen", rd, {16'h0, MAX_DECEL_TORQ});
   endtask

   task automatic s_enable(input logic [31:0] rel, input logic [31:0] stat);
      int w;
      apb(1'b1, REG_REL_DELAY, rel);
      apb(1'b1, REG_STAT_DELAY, stat);
      targetSpeed <= 13'h0;
      posCmdValid <= 1'b1;
      apb(1'b1, REG_CONTROL, 32'h1);
      waitFor(holdBrake, 1'b0, 4);
      waitFor(posCmdAccept, 1'b1, 700);
      w = (rel > stat ? rel : stat) * 10 * TMS;
      chk("acceptDelay", n > w - 105 && n <= w + 5, 32'h1);
      posCmdValid <= 1'b0;
      tick(1);
      chk("acceptDrop", posCmdAccept, 32'h0);
      apb(1'b1, REG_CONTROL, 32'h0);
      tick(1);
      chk("brakeFirst", {holdBrake, motorPower}, 32'h3);
      waitFor(motorPower, 1'b0, 600);
      w = stat * 10 * TMS;
      chk("powerHold", n > w - 110 && n <= w + 5, 32'h1);
   endtask

   task automatic s_rot(input logic [31:0] thr);
      apb(1'b1, REG_STAT_DELAY, 32'h0);
      apb(1'b1, REG_REL_DELAY, 32'h0);
      apb(1'b1, REG_SPEED_THR, thr);
      apb(1'b1, REG_ROT_WAIT, 32'h2);
      apb(1'b1, REG_STOP_MODE, 32'h1);
      targetSpeed <= 13'h3e8;
      apb(1'b1, REG_CONTROL, 32'h1);
      tick(3);
      apb(1'b1, REG_CONTROL, 32'h0);
      tick(1);
      chk("rotPower", {holdBrake, motorPower, dynamicBrake}, 32'h1);
      waitFor(holdBrake, 1'b1, 400);
      chk("rotBrake", thr == 0 ? n > 90 && n <= 205 : n <= 2, 32'h1);
      // base mode 1 lets go of the dynamic brake once the shaft is still
      tick(12);
      chk("dbRelease", dynamicBrake, 32'h0);
   endtask

   task automatic s_forced();
      apb(1'b1, REG_SPEED_THR, 32'h1770);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, REG_STOP_MODE, 32'(m) << 4);
         apb(1'b1, REG_CONTROL, 32'h1);
         tick(3);
         apb(1'b1, REG_CONTROL, 32'h3);
         tick(1);
         chk("forced", {decelTimeMode, decelTorqueMode, motorPower, dynamicBrake},
             {m == 2, m == 1, m != 0, m == 0});
         waitFor(holdBrake, 1'b1, 50);
         apb(1'b1, REG_CONTROL, 32'h0);
         waitFor(motorPower, 1'b0, 50);
         chk("offDb", dynamicBrake, 32'h1);
      end
   endtask

   task automatic s_base();
      for (int b = 0; b < 3; b++) begin
         apb(1'b1, REG_STOP_MODE, 32'(b));
         tick(1);
         chk("baseDb", dynamicBrake, {31'h0, b == 0});
      end
   endtask

   task automatic s_index(input logic [31:0] wd);
      int u;
      apb(1'b1, REG_IDX_WIDTH, wd);
      apb(1'b1, REG_CONTROL, 32'h1);
      waitFor(indexPulse, 1'b1, 17000);
      waitFor(indexPulse, 1'b0, 11000);
      u = (wd == 0 ? 1 : wd) * TMS;
      chk("indexWidth", n > u - TMS && n <= u + 2, 32'h1);
      apb(1'b1, REG_CONTROL, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      tick(5);
      rst <= 1'b0;
      tick(1);
      s_reset();
      s_regs();
      s_freeze();
      s_enable(32'h5, 32'h2);
      s_enable(32'h1, 32'h4);
      s_rot(32'h7d0);
      s_rot(32'h0);
      s_forced();
      s_base();
      s_index(32'h0);
      s_index(32'h3e8);
      wrap_up();
   end
endmodule
